// [timer_csr_pkg.sv]
// Package with register map, field positions and timing counts
package timer_csr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [11:0] countdown_timer_config_off = 12'h08c;
  localparam logic [11:0] countdown_timer_count_off  = 12'h090;
  localparam logic [11:0] free_running_counter_off   = 12'h09c;
  localparam logic [11:0] software_reset_control_off = 12'h1f8;
  localparam logic [11:0] irq_status_off             = 12'h0a0;
  localparam logic [11:0] irq_clear_off              = 12'h0a4;
  localparam logic [11:0] irq_enable_off             = 12'h0a8;

  // ==========================================================================
  // Field positions and reset values
  localparam int          timer_run_bit          = 29;
  localparam int          virtual_phy_reset_request_bit           = 3;
  localparam int          second_port_phy_reset_request_bit           = 2;
  localparam logic [15:0] preload_reset          = 16'hffff;
  localparam logic [15:0] count_reset            = 16'hffff;
  localparam logic [31:0] free_run_reset         = 32'h00000000;
  localparam int          irq_timer_bit          = 0;

  // ==========================================================================
  // Timing
  localparam int clk_period_ns      = 100;
  localparam int ref_period_ns      = 40;
  localparam int phy_hold_us        = 102;
  localparam int phy_hold_cycles    = (phy_hold_us * 1000 + clk_period_ns - 1) / clk_period_ns;
  localparam int free_clear_ns      = 160;
  localparam int free_clear_cycles  = (free_clear_ns / clk_period_ns) < 1 ? 1 :
                                      (free_clear_ns / clk_period_ns);

  typedef enum logic [1:0] {
    phy_idle = 2'b00,
    phy_hold = 2'b01,
    phy_wait = 2'b11
  } phy_state_e;

endpackage : timer_csr_pkg

// [phy_reset_seq.sv]
// Self-clearing PHY reset sequencer with minimum hold time
`timescale 1ns/10ps
module phy_reset_seq
  import timer_csr_pkg::*;
#(
  parameter int HOLD_CYCLES = phy_hold_cycles
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic released,
  output logic      phy_reset,
  output logic      busy
);

  // ==========================================================================
  // State and hold counter
  phy_state_e  state_ff;
  phy_state_e  nxt_state;
  logic [31:0] hold_ff;
  logic [31:0] nxt_hold;
  wire         hold_done = (hold_ff >= 32'(HOLD_CYCLES - 1));

  always_comb begin
    nxt_state = state_ff;
    nxt_hold  = hold_ff;
    unique case (state_ff)
      phy_idle: begin
        nxt_hold = '0;
        if (start) begin
          nxt_state = phy_hold;
        end
      end
      phy_hold: begin
        nxt_hold = hold_ff + 32'd1;
        if (hold_done) begin
          nxt_state = phy_wait;
        end
      end
      phy_wait: begin
        if (released) begin
          nxt_state = phy_idle;
        end
      end
      default: nxt_state = phy_idle;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= phy_idle;
      hold_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      hold_ff  <= nxt_hold;
    end
  end

  assign phy_reset = (state_ff == phy_hold);
  assign busy      = (state_ff != phy_idle);

endmodule : phy_reset_seq

// [timer_csr.sv]
// Countdown timer, free-running counter and PHY reset control registers
// Operation
// [RULE_01] Countdown timer runs while enable bit 29 is one, halts otherwise.
// [RULE_02] Enable falling one to zero forces the preload field to ffff.
// [RULE_03] Timer starts from preload bits 15:0 and decrements while enabled.
// [RULE_04] Timer can raise a host interrupt at the preload interval.
// [RULE_05] Live timer count readable as 16-bit field, resets to ffff.
// [RULE_06] Free-running 32-bit counter clears on reset, adds one per 25MHz cycle.
// [RULE_07] Free-running counter wraps to zero at maximum and keeps counting.
// [RULE_08] Full free-running count captured on first read, coherent across halves.
// [RULE_09] Free-running counter may take up to 160ns to clear after reset.
// [RULE_10] Reset control register answers reads even in reset or not ready.
// [RULE_11] Either 16-bit half of reset control can be read alone.
// [RULE_12] Bit 3 write one resets virtual PHY; bit self-clears on release.
// [RULE_13] Bit 2 write one resets second PHY at least 102us, self-clears.
// [RULE_14] Writes to a self-clearing reset bit ignored while it reads one.
// [RULE_15] Configuration loader cannot set or clear the PHY reset bits.
// [RULE_16] Timer reaching zero flags interrupt and reloads from preload.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
module timer_csr
  import timer_csr_pkg::*;
#(
  parameter int PHY_HOLD_CYCLES = phy_hold_cycles
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ref_tick,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  input  wire logic        loader_wr,
  input  wire logic        vphy_released,
  input  wire logic        phy2_released,
  output logic      [31:0] rdata,
  output logic             irq,
  output logic             vphy_reset,
  output logic             phy2_reset
);

  // ==========================================================================
  // Address decode
  wire sel_cfg   = (addr == countdown_timer_config_off);
  wire sel_cnt   = (addr == countdown_timer_count_off);
  wire sel_free  = (addr == free_running_counter_off);
  wire sel_rst   = (addr == software_reset_control_off);
  wire sel_sts   = (addr == irq_status_off);
  wire sel_clr   = (addr == irq_clear_off);
  wire sel_ena   = (addr == irq_enable_off);
  // Loader writes never reach the PHY reset bits
  // [RULE_15] Loader write block
  wire host_wr   = wr & ~loader_wr;
  wire wr_cfg    = wr & sel_cfg;
  wire wr_rst    = host_wr & sel_rst;
  wire wr_clr    = wr & sel_clr;
  wire wr_ena    = wr & sel_ena;

  // ==========================================================================
  // Countdown timer
  logic        run_ff;
  logic [15:0] preload_ff;
  logic [15:0] count_ff;
  logic        nxt_run;
  logic [15:0] nxt_preload;
  logic [15:0] nxt_count;

  wire   run_fall = run_ff & ~nxt_run;
  wire   run_rise = ~run_ff & nxt_run;
  wire   expire   = run_ff & (count_ff == 16'h0000);

  assign nxt_run = wr_cfg ? wdata[timer_run_bit] : run_ff;

  always_comb begin
    nxt_preload = preload_ff;
    if (wr_cfg) begin
      nxt_preload = wdata[15:0];
    end
    // [RULE_02] Preload forced high
    if (run_fall) begin
      nxt_preload = preload_reset;
    end
  end

  always_comb begin
    nxt_count = count_ff;
    if (run_rise) begin
      // [RULE_03] Start from preload
      nxt_count = nxt_preload;
    end else if (expire) begin
      // [RULE_16] Reload on zero
      nxt_count = preload_ff;
    end else if (run_ff) begin
      // [RULE_01] Decrement while enabled
      nxt_count = count_ff - 16'd1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_ff     <= 1'b0;
      preload_ff <= preload_reset;
      // [RULE_05] Count resets high
      count_ff   <= count_reset;
    end else begin
      run_ff     <= nxt_run;
      preload_ff <= nxt_preload;
      count_ff   <= nxt_count;
    end
  end

  // ==========================================================================
  // Free-running counter
  logic [31:0] free_ff;

  // [RULE_06] Clear then count ref ticks
  // [RULE_07] Natural wrap at maximum
  // [RULE_09] Cleared within one clock
  wire [31:0] nxt_free = ref_tick ? free_ff + 32'd1 : free_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      free_ff <= free_run_reset;
    end else begin
      free_ff <= nxt_free;
    end
  end

  // ==========================================================================
  // PHY reset request bits
  logic vphy_busy;
  logic phy2_busy;

  // [RULE_14] Ignore writes while set
  wire vphy_start = wr_rst & wdata[virtual_phy_reset_request_bit] & ~vphy_busy;
  wire phy2_start = wr_rst & wdata[second_port_phy_reset_request_bit] & ~phy2_busy;

  // [RULE_12] Virtual PHY reset, no hold time
  phy_reset_seq #(
    .HOLD_CYCLES (1)
  ) u_vphy (
    .clk       (clk),
    .rst       (rst),
    .start     (vphy_start),
    .released  (vphy_released),
    .phy_reset (vphy_reset),
    .busy      (vphy_busy)
  );

  // [RULE_13] Second PHY reset with hold
  phy_reset_seq #(
    .HOLD_CYCLES (PHY_HOLD_CYCLES)
  ) u_phy2 (
    .clk       (clk),
    .rst       (rst),
    .start     (phy2_start),
    .released  (phy2_released),
    .phy_reset (phy2_reset),
    .busy      (phy2_busy)
  );

  // ==========================================================================
  // Interrupt status, clear and enable
  logic irq_sts_ff;
  logic irq_ena_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_sts_ff <= 1'b0;
      irq_ena_ff <= 1'b0;
    end else begin
      // [RULE_16] Set wins over clear
      irq_sts_ff <= expire | (irq_sts_ff & ~(wr_clr & wdata[irq_timer_bit]));
      if (wr_ena) begin
        irq_ena_ff <= wdata[irq_timer_bit];
      end
    end
  end

  // [RULE_04] Interrupt output
  assign irq = irq_sts_ff & irq_ena_ff;

  // ==========================================================================
  // Read data
  wire [31:0] cfg_view  = {2'b00, run_ff, 13'h0000, preload_ff};
  wire [31:0] cnt_view  = {16'h0000, count_ff};
  wire [31:0] free_view = free_ff;
  // [RULE_10] Always readable
  // [RULE_11] Both halves in one word
  wire [31:0] rst_view  = {28'h0000000, vphy_busy, phy2_busy, 2'b00};
  wire [31:0] sts_view  = {31'h00000000, irq_sts_ff};
  wire [31:0] ena_view  = {31'h00000000, irq_ena_ff};

  wire [31:0] rd_mux =
      sel_cfg  ? cfg_view  :
      sel_cnt  ? cnt_view  :
      sel_free ? free_view :
      sel_rst  ? rst_view  :
      sel_sts  ? sts_view  :
      sel_ena  ? ena_view  : 32'h00000000;

  // [RULE_08] Whole word captured once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 32'h00000000;
    end else if (rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 32'h00000000;
    end
  end

endmodule : timer_csr

// [timer_csr_chk.sv]
// Assertion checker for the timer register block
`timescale 1ns/10ps
module timer_csr_chk
  import timer_csr_pkg::*;
#(
  parameter int PHY_HOLD_CYCLES = phy_hold_cycles
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        ref_tick,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic        loader_wr,
  input wire logic        vphy_released,
  input wire logic        phy2_released,
  input wire logic [31:0] rdata,
  input wire logic        irq,
  input wire logic        vphy_reset,
  input wire logic        phy2_reset
);
  // ========
  // Helpers
  int  hold_ff;
  wire ctl_sel = addr == software_reset_control_off;
  wire ctl_wr  = wr && !loader_wr && ctl_sel;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) hold_ff <= 0;
    else hold_ff <= phy2_reset ? hold_ff + 1 : 0;
  end
  // Reference count of ticks since reset
  logic [31:0] tick_cnt_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) tick_cnt_ff <= 32'h0;
    else if (ref_tick) tick_cnt_ff <= tick_cnt_ff + 32'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_ctl_rd; rd && ctl_sel; endsequence
  sequence s_hold_end; phy2_reset ##1 !phy2_reset; endsequence
  // ========
  // Properties
  property p_ctl_rsvd; s_ctl_rd |=> rdata[31:4] == 28'h0; endproperty
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reset control spare bits set");
  property p_cfg_rsvd; rd && addr == countdown_timer_config_off
    |=> rdata[31:30] == 2'h0 && rdata[28:16] == 13'h0; endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("config spare bits set");
  property p_cnt_rsvd; rd && addr == countdown_timer_count_off |=> rdata[31:16] == 16'h0; endproperty
  a_cnt_rsvd: assert property (p_cnt_rsvd) else $error("count spare bits set");
  property p_phy2_hold; s_hold_end |-> hold_ff >= PHY_HOLD_CYCLES; endproperty
  a_phy2_hold: assert property (p_phy2_hold) else $error("phy2 reset too short");
  property p_phy2_cause; $rose(phy2_reset) |-> $past(ctl_wr && wdata[2]); endproperty
  a_phy2_cause: assert property (p_phy2_cause) else $error("phy2 reset without write");
  property p_vphy_cause; $rose(vphy_reset) |-> $past(ctl_wr && wdata[3]); endproperty
  a_vphy_cause: assert property (p_vphy_cause) else $error("vphy reset without write");
  property p_vphy_pulse; vphy_reset |=> !vphy_reset; endproperty
  a_vphy_pulse: assert property (p_vphy_pulse) else $error("vphy reset too long");
  property p_loader; wr && loader_wr |=> !$rose(phy2_reset) && !$rose(vphy_reset); endproperty
  a_loader: assert property (p_loader) else $error("loader started a reset");
  property p_free_read; rd && addr == free_running_counter_off
    |=> rdata == $past(tick_cnt_ff); endproperty
  a_free_read: assert property (p_free_read) else $error("free count read wrong");
endmodule : timer_csr_chk

bind timer_csr timer_csr_chk #(.PHY_HOLD_CYCLES(PHY_HOLD_CYCLES)) chk_i (.clk(clk), .rst(rst),
  .ref_tick(ref_tick), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .loader_wr(loader_wr),
  .vphy_released(vphy_released), .phy2_released(phy2_released), .rdata(rdata), .irq(irq),
  .vphy_reset(vphy_reset), .phy2_reset(phy2_reset));

// [tb_top.sv]
// Self-checking testbench for the timer register block
`timescale 1ns/10ps
module tb_top
  import timer_csr_pkg::*;
;
  localparam int          hold_n = 4;
  localparam logic [11:0] ctl    = software_reset_control_off;
  localparam logic [11:0] cfg    = countdown_timer_config_off;
  logic        clk = 0, rst = 1, ref_tick = 0, wr = 0, rd = 0, loader_wr = 0;
  logic        vphy_released = 0, phy2_released = 0, tick_en = 0;
  logic [11:0] addr = 12'h0;
  logic [15:0] pre;
  logic [31:0] wdata = 32'h0, seed = 32'h702d20d5, ticks = 32'h0;
  wire  [31:0] rdata;
  wire         irq, vphy_reset, phy2_reset;
  int          miscompares = 0, total_checks = 0, n;
  timer_csr #(.PHY_HOLD_CYCLES(hold_n)) uut (.clk(clk), .rst(rst), .ref_tick(ref_tick),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .loader_wr(loader_wr),
    .vphy_released(vphy_released), .phy2_released(phy2_released), .rdata(rdata),
    .irq(irq), .vphy_reset(vphy_reset), .phy2_reset(phy2_reset));
  initial begin
    forever #50 clk = ~clk;
  end
  // Random reference ticks, counted
  always @(posedge clk) begin
    if (ref_tick) ticks <= ticks + 1;
    ref_tick <= tick_en && ($random(seed) % 2 != 0);
  end
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask : wr_reg
  task automatic rd_chk(logic [11:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask : rd_chk
  task automatic tally_and_finish();
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    rd_chk(cfg, 32'h0000ffff);
    rd_chk(countdown_timer_count_off, 32'h0000ffff);
    rd_chk(12'h004, 32'h0);
    tick_en <= 1;
    repeat (150) @(posedge clk);
    tick_en <= 0;
    repeat (3) @(posedge clk);
    rd_chk(free_running_counter_off, ticks);
    wr_reg(irq_enable_off, 32'h1);
    rd_chk(irq_enable_off, 32'h1);
    for (int i = 0; i < 4; i++) begin
      pre = (i == 0) ? 16'h1 : 16'(2 + {$random(seed)} % 9);
      wr_reg(cfg, 32'h20000000 | 32'(pre));
      n = 0;
      while (irq !== 1'b1 && n < 40) begin
        @(posedge clk);
        #1 n++;
      end
      chk(n, 32'(pre) + 1);
      rd_chk(countdown_timer_count_off, 32'(pre) - 1);
      wr_reg(cfg, 32'h0);
      wr_reg(irq_clear_off, 32'h1);
      #1 chk(irq, 0);
      rd_chk(cfg, 32'h0000ffff);
    end
    repeat (20) @(posedge clk);
    #1 chk(irq, 0);
    wr_reg(ctl, 32'h4);
    #1 n = 0;
    while (phy2_reset === 1'b1 && n < 99) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n, hold_n);
    wr_reg(ctl, 32'h4);
    #1 chk(phy2_reset, 0);
    rd_chk(ctl, 32'h4);
    @(posedge clk) phy2_released <= 1;
    repeat (3) @(posedge clk);
    rd_chk(ctl, 32'h0);
    wr_reg(ctl, 32'h8);
    #1 chk(vphy_reset, 1);
    rd_chk(ctl, 32'h8);
    @(posedge clk) vphy_released <= 1;
    repeat (3) @(posedge clk);
    rd_chk(ctl, 32'h0);
    @(posedge clk) loader_wr <= 1;
    wr_reg(ctl, 32'hc);
    rd_chk(ctl, 32'h0);
    @(posedge clk) rst <= 1;
    @(posedge clk) rst <= 0;
    rd_chk(free_running_counter_off, 32'h0);
    tally_and_finish();
  end
endmodule : tb_top
